// ### inc/stpsm_pkg.sv
// Purpose: shared constants and types for the stepper output smoothing path
// Assumes: one 200 MHz clock, sample tick derived internally
// Notes: motor type codes are the documented values times two
package stpsm_pkg;
  localparam int POS_W = 32;
  localparam int CLK_PERIOD_NS = 5;
  // motor type codes, in half units
  localparam logic [7:0] MT_LOW_NORM = 8'h04;
  localparam logic [7:0] MT_HIGH_NORM = 8'hFC;
  localparam logic [7:0] MT_LOW_REV = 8'h05;
  localparam logic [7:0] MT_HIGH_REV = 8'hFB;
  localparam logic [7:0] MT_RST = 8'h00;
  // step smoothing constant in thousandths, tau = 3 * ks samples
  localparam logic [15:0] KS_RST = 16'h0521;
  localparam logic [4:0] KS_TAU_MULT = 5'h03;
  localparam logic [25:0] ALPHA_DIVIDEND = 26'h3E80000;
  localparam logic [16:0] ALPHA_ONE = 17'h10000;
  // 65536000 / (3 * 1313), truncated
  localparam logic [16:0] ALPHA_RST = 17'h040FD;
  localparam int DIV_STEPS = 26;
  // profile smoothing constant, fraction of 256; 256 means none
  localparam logic [8:0] IT_RST = 9'h100;
  localparam int IT_FRAC = 8;
  localparam int KS_FRAC = 16;
  // timing
  localparam int SAMPLE_PERIOD_NS = 1000000;
  localparam int SAMPLE_CYC = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int STEP_HIGH_NS = 250;
  localparam int STEP_LOW_NS = 250;
  localparam int STEP_HIGH_CYC = (STEP_HIGH_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int STEP_LOW_CYC = (STEP_LOW_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  typedef struct packed {
    logic [7:0] motor_type_select;
    logic [15:0] step_smoothing_constant;
    logic [8:0] profile_smoothing_time_constant;
  } stpsm_cfg_t;
  typedef enum logic [1:0] {ST_IDLE, ST_PULSE, ST_GAP} stpsm_state_t;
endpackage

// ### core/stpsm_core.sv
// Purpose: one axis of profile smoothing, step smoothing and step/dir output
// Assumes: inputs synchronous to clock_i; cmd_pos_i sampled each sample tick
// Notes: settings enter through cfg_i on cfg_load_i
// Function
// - type code 2 gives active-low step pulses, normal direction.
// - type code -2 gives active-high step pulses, normal direction.
// - type code 2.5 gives active-low steps and inverted direction.
// - type code -2.5 gives active-high steps and inverted direction.
// - step smoothing is a single-pole low-pass after the profiler.
// - smoothing delays step pulses per the programmed time constant.
// - in stepper mode the smoothing filter is always in the path.
// - profiler done is independent of pending filtered steps.
// - separate profile smoothing stage with its own time constant.
// - after reset smoothing constant is 1.313, tau 3.939 samples.
// - emitted steps are counted; define-position loads count and reference.
`timescale 1ns/1ps
module stpsm_core #(
  parameter int SAMPLE_CYCLES = stpsm_pkg::SAMPLE_CYC
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire stpsm_pkg::stpsm_cfg_t cfg_i,
  input wire logic cfg_load_i,
  input wire logic signed [stpsm_pkg::POS_W-1:0] cmd_pos_i,
  input wire logic profile_done_i,
  input wire logic dp_load_i,
  input wire logic signed [stpsm_pkg::POS_W-1:0] dp_value_i,
  output logic step_o,
  output logic dir_o,
  output logic signed [stpsm_pkg::POS_W-1:0] emitted_step_count_o,
  output logic signed [stpsm_pkg::POS_W-1:0] ref_pos_o,
  output logic profile_done_o,
  output logic steps_pending_o
);
  localparam int PW = stpsm_pkg::POS_W;
  localparam int RW = PW + stpsm_pkg::IT_FRAC;
  localparam int FW = PW + stpsm_pkg::KS_FRAC;
  localparam int TW = $clog2(SAMPLE_CYCLES + 1);

  stpsm_pkg::stpsm_cfg_t cfg;
  stpsm_pkg::stpsm_state_t st;
  logic [TW-1:0] tick_cnt;
  logic [6:0] ptimer;
  logic [16:0] alpha;
  logic [25:0] quot;
  logic [26:0] rem;
  logic [17:0] divisor;
  logic [4:0] div_cnt;
  logic div_busy;
  logic ks_touched;
  logic signed [RW-1:0] ref_q;
  logic signed [FW-1:0] filt_q;
  logic signed [PW-1:0] count;
  logic dir_pos;

  function automatic logic [2:0] mt_decode(input logic [7:0] mt);
    // {stepper, active_low, reversed}
    unique case (mt)
      stpsm_pkg::MT_LOW_NORM: mt_decode = 3'h6;
      stpsm_pkg::MT_HIGH_NORM: mt_decode = 3'h4;
      stpsm_pkg::MT_LOW_REV: mt_decode = 3'h7;
      stpsm_pkg::MT_HIGH_REV: mt_decode = 3'h5;
      default: mt_decode = 3'h0;
    endcase
  endfunction

  wire [2:0] mt_dec = mt_decode(cfg.motor_type_select);
  wire is_stepper = mt_dec[2];
  wire active_low = mt_dec[1];
  wire reversed = mt_dec[0];
  wire tick = (tick_cnt == TW'(SAMPLE_CYCLES - 1));

  // profile smoothing filter
  wire signed [RW-1:0] err_p = RW'(cmd_pos_i) <<< stpsm_pkg::IT_FRAC;
  wire signed [RW-1:0] diff_p = err_p - ref_q;
  wire signed [RW+10:0] prod_p = (RW+11)'(diff_p)
    * (RW+11)'($signed({1'b0, cfg.profile_smoothing_time_constant}))
    + (RW+11)'(128);
  wire signed [RW-1:0] next_ref_q = ref_q
    + RW'(prod_p >>> stpsm_pkg::IT_FRAC);

  // step smoothing filter
  wire signed [FW-1:0] ref_f = FW'(ref_q) <<< (FW - RW);
  wire signed [FW-1:0] diff_f = ref_f - filt_q;
  wire signed [FW+17:0] prod_f = (FW+18)'(diff_f)
    * (FW+18)'($signed({1'b0, alpha}))
    + (FW+18)'(32768);
  wire signed [FW-1:0] next_filt_q = filt_q
    + FW'(prod_f >>> stpsm_pkg::KS_FRAC);
  wire signed [FW-1:0] filt_rnd = filt_q + FW'(32768);
  wire signed [PW-1:0] target = PW'(filt_rnd >>> stpsm_pkg::KS_FRAC);

  wire pending = (target != count);
  wire want_dir = (target > count);
  wire start_pulse = (st == stpsm_pkg::ST_IDLE) && is_stepper && pending
                     && (want_dir == dir_pos);
  wire turn_dir = (st == stpsm_pkg::ST_IDLE) && is_stepper && pending
                  && (want_dir != dir_pos);
  wire pulse_on = (st == stpsm_pkg::ST_PULSE);
  wire alpha_bit = stpsm_pkg::ALPHA_DIVIDEND[div_cnt];
  wire [26:0] rem_sh = {rem[25:0], alpha_bit};
  wire rem_ge = (rem_sh >= 27'(divisor));
  wire [16:0] alpha_new = (quot > 26'(stpsm_pkg::ALPHA_ONE))
                          ? stpsm_pkg::ALPHA_ONE : quot[16:0];

  // sample tick divider
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) tick_cnt <= '0;
    else tick_cnt <= tick ? '0 : tick_cnt + TW'(1);
  end

  // settings; reciprocal of tau by serial division
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg <= '{stpsm_pkg::MT_RST, stpsm_pkg::KS_RST, stpsm_pkg::IT_RST};
      alpha <= stpsm_pkg::ALPHA_RST;
      ks_touched <= 1'b0;
      div_busy <= 1'b0;
      div_cnt <= '0;
      divisor <= '0;
      rem <= '0;
      quot <= '0;
    end else if (cfg_load_i && !div_busy) begin
      cfg <= cfg_i;
      ks_touched <= 1'b1;
      div_busy <= 1'b1;
      div_cnt <= 5'(stpsm_pkg::DIV_STEPS - 1);
      // widen before the product so large constants do not wrap
      divisor <= 18'(cfg_i.step_smoothing_constant)
                 * 18'(stpsm_pkg::KS_TAU_MULT);
      rem <= '0;
      quot <= '0;
    end else if (div_busy) begin
      rem <= rem_ge ? rem_sh - 27'(divisor) : rem_sh;
      quot <= {quot[24:0], rem_ge};
      div_cnt <= div_cnt - 5'h01;
      if (div_cnt == 5'h00) div_busy <= 1'b0;
    end else if (ks_touched && alpha != alpha_new && quot != '0) begin
      alpha <= alpha_new;
    end
  end

  // both filters advance once per sample; define-position preloads them
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ref_q <= '0;
      filt_q <= '0;
    end else if (dp_load_i) begin
      ref_q <= RW'(dp_value_i) <<< stpsm_pkg::IT_FRAC;
      filt_q <= FW'(dp_value_i) <<< stpsm_pkg::KS_FRAC;
    end else if (tick) begin
      ref_q <= next_ref_q;
      filt_q <= next_filt_q;
    end
  end

  // step engine: direction settles for a gap before the first pulse after a reversal
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= stpsm_pkg::ST_IDLE;
      ptimer <= '0;
      dir_pos <= 1'b1;
      count <= '0;
    end else begin
      if (dp_load_i) count <= dp_value_i;
      else if (start_pulse) count <= dir_pos ? count + 1 : count - 1;
      unique case (st)
        stpsm_pkg::ST_IDLE: begin
          if (start_pulse) begin
            st <= stpsm_pkg::ST_PULSE;
            ptimer <= 7'(stpsm_pkg::STEP_HIGH_CYC - 1);
          end else if (turn_dir) begin
            dir_pos <= want_dir;
            st <= stpsm_pkg::ST_GAP;
            ptimer <= 7'(stpsm_pkg::STEP_LOW_CYC - 1);
          end
        end
        stpsm_pkg::ST_PULSE: begin
          ptimer <= ptimer - 7'h01;
          if (ptimer == 7'h00) begin
            st <= stpsm_pkg::ST_GAP;
            ptimer <= 7'(stpsm_pkg::STEP_LOW_CYC - 1);
          end
        end
        stpsm_pkg::ST_GAP: begin
          ptimer <= ptimer - 7'h01;
          if (ptimer == 7'h00) st <= stpsm_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // registered outputs
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      step_o <= 1'b0;
      dir_o <= 1'b0;
      profile_done_o <= 1'b0;
      steps_pending_o <= 1'b0;
    end else begin
      step_o <= is_stepper & (pulse_on ^ active_low);
      dir_o <= is_stepper & (dir_pos ^ reversed);
      profile_done_o <= profile_done_i;
      steps_pending_o <= pending | (st != stpsm_pkg::ST_IDLE);
    end
  end
  assign emitted_step_count_o = count;
  assign ref_pos_o = PW'(ref_q >>> stpsm_pkg::IT_FRAC);

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  sequence pulse_body_s;
    pulse_on [*8] ##42 pulse_on ##1 !pulse_on;
  endsequence
  invalid_type_idle_a: assert property (
    !is_stepper |=> !step_o && !dir_o) else $error("outputs not idle");
  low_idle_level_a: assert property (
    is_stepper && active_low && st == stpsm_pkg::ST_IDLE |=> step_o)
    else $error("active-low idle not high");
  high_pulse_level_a: assert property (
    is_stepper && !active_low && pulse_on |=> step_o)
    else $error("active-high pulse missing");
  dir_inverted_a: assert property (
    is_stepper && reversed && $stable(cfg) |=> dir_o != $past(dir_pos))
    else $error("reversed direction not inverted");
  pulse_width_a: assert property (
    start_pulse |=> pulse_body_s) else $error("pulse width wrong");
  count_per_step_a: assert property (
    start_pulse && !dp_load_i |=>
    count == $past(count) + ($past(dir_pos) ? 1 : -1))
    else $error("count does not follow step");
  only_filtered_a: assert property (
    st == stpsm_pkg::ST_IDLE ##1 pulse_on |-> $past(pending))
    else $error("step without filter pending");
  dp_load_a: assert property (
    dp_load_i |=> count == $past(dp_value_i) && ref_pos_o == $past(dp_value_i))
    else $error("define position not loaded");
  ks_default_a: assert property (
    !ks_touched |-> alpha == stpsm_pkg::ALPHA_RST
    && cfg.step_smoothing_constant == stpsm_pkg::KS_RST)
    else $error("smoothing default wrong");
  done_passthru_a: assert property (
    1'b1 |=> profile_done_o == $past(profile_done_i))
    else $error("done depends on filter");
  filter_toward_a: assert property (
    tick && !dp_load_i && filt_q < ref_f |=> filt_q >= $past(filt_q)
    && filt_q <= $past(ref_f)) else $error("filter overshoots");
endmodule // stpsm_core

// ### testbench/stpsm_drive_model.sv
// Purpose: external step drive that counts the pulses it receives
// Assumes: polarity and direction sense are set by the bench
// Notes: counts only on entry to the active level from idle
`timescale 1ns/1ps
module stpsm_drive_model (
  input wire logic step_i,
  input wire logic dir_i,
  input wire logic active_high_i,
  input wire logic reversed_i,
  output logic signed [31:0] pos_o
);
  logic prev = 1'bx;
  initial pos_o = '0;
  // a level change at reset or at a type change is no step
  always @(step_i) begin
    if (step_i === active_high_i && prev === ~active_high_i) begin
      if ((dir_i ^ reversed_i) === 1'b1) begin
        pos_o = pos_o + 32'sh1;
      end else begin
        pos_o = pos_o - 32'sh1;
      end
    end
    prev = step_i;
  end
endmodule // stpsm_drive_model

// ### testbench/stpsm_core_tb.sv
// Purpose: self-checking bench for stpsm_core
// Assumes: sample period shortened to 200 clocks
// Notes: each scenario is one task
`timescale 1ns/1ps
module stpsm_core_tb;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  stpsm_pkg::stpsm_cfg_t cfg_i = '0;
  logic cfg_load_i = 1'b0;
  logic dp_load_i = 1'b0;
  logic profile_done_i = 1'b0;
  logic signed [31:0] cmd_pos_i = '0;
  logic signed [31:0] dp_value_i = '0;
  logic step_o, dir_o, profile_done_o, steps_pending_o;
  logic signed [31:0] emitted_step_count_o, ref_pos_o, drv_pos;
  logic hi = 1'b0;
  logic rev = 1'b0;
  int num_errors = 0;
  int check_count = 0;
  stpsm_core #(.SAMPLE_CYCLES(200)) stpsm_core_inst (.clock_i(clock_i),
    .rst_b_i(rst_b_i), .cfg_i(cfg_i), .cfg_load_i(cfg_load_i),
    .cmd_pos_i(cmd_pos_i), .profile_done_i(profile_done_i),
    .dp_load_i(dp_load_i), .dp_value_i(dp_value_i), .step_o(step_o),
    .dir_o(dir_o), .emitted_step_count_o(emitted_step_count_o),
    .ref_pos_o(ref_pos_o), .profile_done_o(profile_done_o),
    .steps_pending_o(steps_pending_o));
  stpsm_drive_model stpsm_drive_model_inst (.step_i(step_o),
    .dir_i(dir_o), .active_high_i(hi), .reversed_i(rev), .pos_o(drv_pos));
  initial begin
    forever #2.5 clock_i = ~clock_i;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic load(input logic [7:0] code, input logic [8:0] it);
    cfg_i = '{code, stpsm_pkg::KS_RST, it};
    cfg_load_i = 1'b1;
    cyc(1);
    cfg_load_i = 1'b0;
    cyc(30);
  endtask
  task automatic wait_ref(input logic [31:0] old);
    int n;
    n = 0;
    while (ref_pos_o === old && n < 400) begin
      cyc(1);
      n++;
    end
    cmp(32'(ref_pos_o !== old), 32'h1);
  endtask
  // then let the filter settle well below one step
  task automatic wait_done(input logic [31:0] tgt);
    int n;
    n = 0;
    while (!(emitted_step_count_o === tgt && steps_pending_o === 1'b0)
           && n < 20000) begin
      cyc(1);
      n++;
    end
    cmp(emitted_step_count_o, tgt);
    cyc(3000);
  endtask
  task automatic t_move(input logic [7:0] code, input logic ah, rv,
                        input logic [31:0] tgt, mid, input logic dexp);
    logic [31:0] start;
    start = ref_pos_o;
    hi = ah;
    rev = rv;
    load(code, stpsm_pkg::IT_RST);
    cmp(step_o, {31'h0, ~ah}); // idle level
    cmd_pos_i = tgt;
    wait_ref(start);
    cyc(5);
    cmp(ref_pos_o, tgt); // no profile smoothing
    cyc(200);
    cmp(32'(emitted_step_count_o !== tgt), 32'h1); // lag
    cmp(profile_done_o, 32'h1); // done early
    cmp(steps_pending_o, 32'h1); // steps still due
    cyc(400);
    cmp(emitted_step_count_o, mid); // three samples
    cmp(dir_o, dexp); // direction sense
    wait_done(tgt); // drained before next move
    cmp(drv_pos, tgt); // pulses really driven
  endtask
  task automatic t_invalid;
    load(8'h10, stpsm_pkg::IT_RST);
    cmp(step_o, 32'h0); // outputs inactive
    cmp(dir_o, 32'h0); // outputs inactive
  endtask
  task automatic t_dp;
    cmd_pos_i = 32'sh64;
    dp_value_i = 32'sh64;
    dp_load_i = 1'b1;
    cyc(1);
    dp_load_i = 1'b0;
    cyc(1);
    cmp(emitted_step_count_o, 32'h64); // count loaded
    cmp(ref_pos_o, 32'h64); // reference loaded
  endtask
  task automatic t_smooth;
    logic [31:0] start;
    start = drv_pos;
    hi = 1'b0;
    rev = 1'b0;
    load(stpsm_pkg::MT_LOW_NORM, 9'h0C0);
    cmd_pos_i = 32'sh8C;
    wait_ref(32'h64);
    cmp(32'(ref_pos_o > 32'sh64 && ref_pos_o < 32'sh8C), 32'h1);
    wait_done(32'h8C); // drained
    cmp(drv_pos, start + 32'h28); // forty steps
  endtask
  // short time constant: filter follows the reference within one sample
  task automatic t_ks;
    cfg_i = '{stpsm_pkg::MT_LOW_NORM, 16'h014D, stpsm_pkg::IT_RST};
    cfg_load_i = 1'b1;
    cyc(1);
    cfg_load_i = 1'b0;
    cyc(30);
    cmd_pos_i = 32'sh8D;
    wait_ref(32'h8C);
    cyc(205);
    cmp(emitted_step_count_o, 32'h8D); // step after one sample
    wait_done(32'h8D); // drained
  endtask
  task automatic summarize;
    $display("num_errors=%0d check_count=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // whole run is near 30000 clocks; allow well over twice that
  initial begin
    #400000;
    num_errors++;
    summarize;
  end
  initial begin
    cyc(12);
    rst_b_i = 1'b1;
    cmp(step_o, 32'h0); // no type yet
    cmp(emitted_step_count_o, 32'h0);
    profile_done_i = 1'b1;
    t_move(stpsm_pkg::MT_LOW_NORM, 1'b0, 1'b0, 32'h4, 32'h2, 1'b1);
    t_move(stpsm_pkg::MT_LOW_REV, 1'b0, 1'b1, 32'h7, 32'h6, 1'b0);
    t_move(stpsm_pkg::MT_HIGH_NORM, 1'b1, 1'b0, 32'h5, 32'h6, 1'b0);
    t_move(stpsm_pkg::MT_HIGH_REV, 1'b1, 1'b1, 32'h3, 32'h4, 1'b1);
    t_invalid;
    t_dp;
    t_smooth;
    t_ks;
    summarize;
  end
endmodule // stpsm_core_tb
